// ===== hw/flutm_pkg.sv
// flutm_pkg: register map, control fields, timing and state codes of the
// flash user test block; shared by the top module and the scan sequencer.
package flutm_pkg;
    // register byte offsets
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_DLO = 8'h04;
    localparam logic [7:0] OFS_DHI = 8'h08;
    localparam logic [7:0] OFS_SIG0 = 8'h0C;
    localparam logic [7:0] OFS_BSEL = 8'h20;
    localparam logic [7:0] OFS_BLOCK = 8'h24;
    localparam logic [7:0] OFS_SLOCK = 8'h28;
    localparam logic [7:0] OFS_STAT = 8'h2C;
    localparam int unsigned WORD_BYTES = 4;
    localparam int unsigned WORD_W = 32;
    localparam int unsigned SIG_WORDS = 5;
    // control register fields
    localparam int unsigned BIT_UTE = 31;
    localparam int unsigned SYN_LSB = 16;
    localparam int unsigned SYN_W = 8;
    localparam int unsigned BIT_MRE = 5;
    localparam int unsigned BIT_MRV = 4;
    localparam int unsigned BIT_EIE = 3;
    localparam int unsigned BIT_AIS = 2;
    localparam int unsigned BIT_AIE = 1;
    localparam int unsigned BIT_AID = 0;
    localparam int unsigned BIT_RWE = 0;
    localparam logic [31:0] TEST_PASSWORD = 32'hF9F9_9999;
    // reset values
    localparam logic [31:0] LOCK_RST = 32'hFFFF_FFFF;
    localparam logic [31:0] ZERO_WORD = 32'h0000_0000;
    // passes: four data slices, then check bits and flags
    localparam logic [2:0] LAST_PASS = 3'h4;
    // signature feedback taps for x^32 + x^22 + x^2 + x + 1
    localparam logic [31:0] MISR_TAPS = 32'h0040_0007;
    // timing
    localparam int unsigned CLK_PERIOD_NS = 10;
    localparam int unsigned MARGIN_WAIT_NS = 40;
    localparam int unsigned MARGIN_WAIT_CYC =
        (MARGIN_WAIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [7:0] MARGIN_WAIT_LD = 8'(MARGIN_WAIT_CYC);
    localparam logic [1:0] NL_EXTRA_CYC = 2'h2;
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_STEP = 2'b01,
        ST_READ = 2'b10,
        ST_HOLD = 2'b11
    } flutm_state_e;
endpackage

// ===== hw/flutm_scan_if.sv
// flutm_scan_if: handshake between the test controller and its address
// sequencer; assumes both sit on pclk.
`timescale 1ns/100ps
interface flutm_scan_if #(parameter int AW = 9) ();
    logic start;
    logic step;
    logic nonlinear;
    logic valid;
    logic last;
    logic [AW-1:0] addr;
    modport gen(input start, input step, input nonlinear,
                output addr, output valid, output last);
    modport ctl(output start, output step, output nonlinear,
                input addr, input valid, input last);
endinterface

// ===== hw/flutm_addr_gen.sv
// flutm_addr_gen: walks every array address, linearly or in bit-reversed
// order; assumes start and step are single-cycle pulses from the controller.
`timescale 1ns/100ps
module flutm_addr_gen #(
    parameter int AW = 9
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // controller side
    flutm_scan_if.gen sc
);
    logic [AW-1:0] idx_ff;
    logic [AW-1:0] rev_w;
    logic valid_ff;
    logic [1:0] pace_ff;

    for (genvar i = 0; i < AW; i++) begin : g_rev
        assign rev_w[i] = idx_ff[AW-1-i];
    end

    assign sc.addr = sc.nonlinear ? rev_w : idx_ff;
    assign sc.valid = valid_ff;
    assign sc.last = &idx_ff;

    // scrambled order pays extra settle cycles on every address
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            idx_ff <= '0;
            valid_ff <= 1'b0;
            pace_ff <= 2'h0;
        end else if (sc.start || sc.step) begin
            idx_ff <= sc.start ? '0 : AW'(idx_ff + 1'b1);
            valid_ff <= 1'b0;
            pace_ff <= sc.nonlinear ? flutm_pkg::NL_EXTRA_CYC : 2'h0;
        end else if (!valid_ff) begin
            valid_ff <= (pace_ff == 2'h0);
            pace_ff <= (pace_ff == 2'h0) ? 2'h0 : 2'(pace_ff - 1'b1);
        end
    end
endmodule

// ===== hw/flutm_top.sv
// flutm_top: flash user test mode logic - integrity scan, margin read and
// ECC logic check, all compressed into five signature words over APB.
// assumes the array answers each read request with one ack pulse and
// holds its outputs until the next request.
// What this block does
// - while test mode is enabled any user array read sets the read error flag
// - a 32-bit signature calculator feeds five readable signature words
// - five full scans; the first four take page bits in 32-bit slices, ascending
// - fifth scan takes both check-bit bytes and both error flag pairs
// - data and check bits uncorrected, error flags after evaluation
// - only selected and unlocked existing blocks feed the signature
// - writing signature words seeds the calculator
// - enable bit sets only on the password write, before any test step
// - blocks under test come from select bits, minus any block locked in either lock register
// - sequential bit picks linear order, else slower scrambled order
// - execute bit starts the test, done flag rises, software clears execute
// - clearing execute before done aborts; done rises when abort completes
// - margin enable biases reads to zeros margin or ones margin by level bit
// - every margin read gets extra wait states before sampling
// - margin mode ends only on read reset; software clears margin bits
// - ECC check forces data and syndrome into both double words
// - ECC check uses loaded data and syndrome when select bit set at start
// - while done is low protected fields read zero and ignore writes
`timescale 1ns/100ps
module flutm_top #(
    parameter int NUM_BLOCKS = 8,
    parameter int PAGE_W = 6
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // user path and flash controller events
    input wire logic user_read_attempt,
    input wire logic read_reset,
    output logic test_mode_active,
    // array read port
    output logic arr_rd_req,
    output logic [$clog2(NUM_BLOCKS)+PAGE_W-1:0] arr_addr,
    input wire logic arr_rd_ack,
    input wire logic [127:0] arr_data,
    input wire logic [15:0] arr_check,
    input wire logic [1:0] arr_sec,
    input wire logic [1:0] arr_ded,
    // margin bias and ecc forcing
    output logic margin_read_enable,
    output logic margin_level,
    output logic ecc_force_en,
    output logic [63:0] forced_data,
    output logic [7:0] forced_syndrome
);
    localparam int BLK_W = $clog2(NUM_BLOCKS);
    localparam int AW = BLK_W + PAGE_W;

    if (NUM_BLOCKS < 2 || NUM_BLOCKS > 31 || PAGE_W < 1) begin : g_chk
        $error("flutm_top: NUM_BLOCKS must be 2..31 and PAGE_W at least 1");
    end

    flutm_scan_if #(.AW(AW)) sc ();

    flutm_addr_gen #(.AW(AW)) u_gen (
        .pclk(pclk),
        .presetn(presetn),
        .sc(sc)
    );

    logic ute_ff, aie_ff, aid_ff, eie_ff, ais_ff, mre_ff, mrv_ff, rwe_ff;
    logic [7:0] syn_ff;
    logic [31:0] dlo_ff, dhi_ff;
    logic [31:0] sig_ff [flutm_pkg::SIG_WORDS];
    logic [NUM_BLOCKS-1:0] bsel_ff, lock_ff, slock_ff;
    flutm_pkg::flutm_state_e st_ff, nxt_st;
    logic [2:0] pass_ff;
    logic [7:0] wait_ff;
    logic mgn_act_ff, mgn_lvl_ff, ecc_ff, req_ff;
    logic [AW-1:0] addr_ff;
    logic [31:0] prdata_ff;
    logic pready_ff, pslverr_ff;

    // bus decode
    wire setup_w = psel && !penable;
    wire wr_w = psel && penable && pready_ff && pwrite;
    wire hit_ctrl = (paddr == flutm_pkg::OFS_CTRL);
    wire hit_dlo = (paddr == flutm_pkg::OFS_DLO);
    wire hit_dhi = (paddr == flutm_pkg::OFS_DHI);
    wire hit_bsel = (paddr == flutm_pkg::OFS_BSEL);
    wire hit_lock = (paddr == flutm_pkg::OFS_BLOCK);
    wire hit_slock = (paddr == flutm_pkg::OFS_SLOCK);
    wire hit_stat = (paddr == flutm_pkg::OFS_STAT);
    logic [flutm_pkg::SIG_WORDS-1:0] sig_hit;
    for (genvar i = 0; i < flutm_pkg::SIG_WORDS; i++) begin : g_hit
        assign sig_hit[i] = (paddr == 8'(flutm_pkg::OFS_SIG0 + flutm_pkg::WORD_BYTES * i));
    end
    wire map_hit = hit_ctrl || hit_dlo || hit_dhi || hit_bsel || hit_lock ||
                   hit_slock || hit_stat || (|sig_hit);

    wire ctrl_wr = wr_w && hit_ctrl;
    wire pw_w = ctrl_wr && (pwdata == flutm_pkg::TEST_PASSWORD);
    wire cfg_wr = ctrl_wr && !pw_w;
    // protected fields writable only while done
    wire prot_wr = cfg_wr && aid_ff;
    // start on execute rising while idle
    wire start_w = cfg_wr && ute_ff && pwdata[flutm_pkg::BIT_AIE] && !aie_ff && aid_ff;

    wire [BLK_W-1:0] blk_w = sc.addr[AW-1:PAGE_W];
    wire blk_ok_w = (32'(blk_w) < NUM_BLOCKS);
    wire elig_w = blk_ok_w && bsel_ff[blk_w] && !lock_ff[blk_w] && !slock_ff[blk_w];

    // data slices in ascending order, check bytes and flags last
    // data and check bits come raw, flags after evaluation
    logic [31:0] slice_w;
    always_comb begin
        if (pass_ff == flutm_pkg::LAST_PASS) begin
            slice_w = {6'h00, arr_ded[1], arr_sec[1], arr_check[15:8],
                       6'h00, arr_ded[0], arr_sec[0], arr_check[7:0]};
        end else begin
            slice_w = arr_data[pass_ff[1:0] * flutm_pkg::WORD_W +: flutm_pkg::WORD_W];
        end
    end

    // feedback shift of the active word, folded with the slice
    wire [31:0] cur_w = sig_ff[pass_ff];
    wire [31:0] misr_nxt = {cur_w[30:0], 1'b0} ^
        (cur_w[31] ? flutm_pkg::MISR_TAPS : flutm_pkg::ZERO_WORD) ^ slice_w;

    logic fold, issue, sc_start, sc_step, finish, pass_end;
    always_comb begin
        nxt_st = st_ff;
        fold = 1'b0;
        issue = 1'b0;
        sc_start = 1'b0;
        sc_step = 1'b0;
        finish = 1'b0;
        pass_end = 1'b0;
        case (st_ff)
            flutm_pkg::ST_IDLE: begin
                if (start_w && eie_ff) begin
                    issue = 1'b1;
                    nxt_st = flutm_pkg::ST_READ;
                end else if (start_w) begin
                    sc_start = 1'b1;
                    nxt_st = flutm_pkg::ST_STEP;
                end
            end
            flutm_pkg::ST_STEP: begin
                if (sc.valid && elig_w) begin
                    issue = 1'b1;
                    nxt_st = flutm_pkg::ST_READ;
                end else if (sc.valid && sc.last) begin
                    pass_end = 1'b1;
                end else if (sc.valid) begin
                    sc_step = 1'b1;
                end
            end
            flutm_pkg::ST_READ: begin
                if (arr_rd_ack && mre_ff) begin
                    nxt_st = flutm_pkg::ST_HOLD;
                end else if (arr_rd_ack) begin
                    fold = 1'b1;
                end
            end
            flutm_pkg::ST_HOLD: begin
                fold = (wait_ff == 8'h00);
            end
            default: begin
                nxt_st = flutm_pkg::ST_IDLE;
            end
        endcase
        if (fold && (eie_ff || sc.last)) begin
            pass_end = 1'b1;
        end else if (fold) begin
            sc_step = 1'b1;
            nxt_st = flutm_pkg::ST_STEP;
        end
        if (pass_end && pass_ff == flutm_pkg::LAST_PASS) begin
            finish = 1'b1;
        end else if (pass_end && eie_ff) begin
            issue = 1'b1;
            nxt_st = flutm_pkg::ST_READ;
        end else if (pass_end) begin
            sc_start = 1'b1;
            nxt_st = flutm_pkg::ST_STEP;
        end
        if (st_ff != flutm_pkg::ST_IDLE && !aie_ff) begin
            finish = 1'b1;
            fold = 1'b0;
            issue = 1'b0;
            sc_start = 1'b0;
            sc_step = 1'b0;
        end
        if (finish) begin
            nxt_st = flutm_pkg::ST_IDLE;
        end
    end

    assign sc.start = sc_start;
    assign sc.step = sc_step;
    assign sc.nonlinear = !ais_ff;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_ff <= flutm_pkg::ST_IDLE;
            pass_ff <= 3'h0;
            wait_ff <= 8'h00;
            req_ff <= 1'b0;
            addr_ff <= '0;
            ecc_ff <= 1'b0;
        end else begin
            st_ff <= nxt_st;
            pass_ff <= start_w ? 3'h0 : (pass_end && !finish) ? 3'(pass_ff + 1'b1) : pass_ff;
            wait_ff <= (st_ff == flutm_pkg::ST_HOLD) ? 8'(wait_ff - 1'b1) :
                       flutm_pkg::MARGIN_WAIT_LD;
            req_ff <= issue;
            // ECC check reads one forced location
            addr_ff <= !issue ? addr_ff : eie_ff ? '0 : sc.addr;
            // forcing holds for the whole check
            ecc_ff <= (start_w && eie_ff) || (ecc_ff && !finish);
        end
    end

    // control register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ute_ff <= 1'b0;
            aie_ff <= 1'b0;
            aid_ff <= 1'b1;
            {eie_ff, ais_ff, mre_ff, mrv_ff} <= 4'h0;
            syn_ff <= 8'h00;
        end else begin
            ute_ff <= pw_w || (ute_ff && !(cfg_wr && !pwdata[flutm_pkg::BIT_UTE]));
            aie_ff <= cfg_wr ? (ute_ff && pwdata[flutm_pkg::BIT_UTE] &&
                                pwdata[flutm_pkg::BIT_AIE]) : aie_ff;
            aid_ff <= finish || (aid_ff && !start_w);
            if (prot_wr) begin
                eie_ff <= pwdata[flutm_pkg::BIT_EIE];
                ais_ff <= pwdata[flutm_pkg::BIT_AIS];
                mre_ff <= pwdata[flutm_pkg::BIT_MRE];
                mrv_ff <= pwdata[flutm_pkg::BIT_MRV];
                syn_ff <= pwdata[flutm_pkg::SYN_LSB +: flutm_pkg::SYN_W];
            end
        end
    end

    // data inputs, block select and locks
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dlo_ff <= flutm_pkg::ZERO_WORD;
            dhi_ff <= flutm_pkg::ZERO_WORD;
            bsel_ff <= '0;
            lock_ff <= NUM_BLOCKS'(flutm_pkg::LOCK_RST);
            slock_ff <= NUM_BLOCKS'(flutm_pkg::LOCK_RST);
        end else begin
            dlo_ff <= (wr_w && hit_dlo && aid_ff) ? pwdata : dlo_ff;
            dhi_ff <= (wr_w && hit_dhi && aid_ff) ? pwdata : dhi_ff;
            bsel_ff <= (wr_w && hit_bsel) ? pwdata[NUM_BLOCKS-1:0] : bsel_ff;
            lock_ff <= (wr_w && hit_lock) ? pwdata[NUM_BLOCKS-1:0] : lock_ff;
            slock_ff <= (wr_w && hit_slock) ? pwdata[NUM_BLOCKS-1:0] : slock_ff;
        end
    end

    // five signature words, seeded by software
    for (genvar i = 0; i < flutm_pkg::SIG_WORDS; i++) begin : g_sig
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                sig_ff[i] <= flutm_pkg::ZERO_WORD;
            end else if (fold && pass_ff == 3'(i)) begin
                sig_ff[i] <= misr_nxt;
            end else if (wr_w && sig_hit[i] && aid_ff) begin
                sig_ff[i] <= pwdata;
            end
        end
    end

    // flags and margin mode
    wire rwe_clr = wr_w && hit_stat && pwdata[flutm_pkg::BIT_RWE];
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rwe_ff <= 1'b0;
            mgn_act_ff <= 1'b0;
            mgn_lvl_ff <= 1'b0;
        end else begin
            rwe_ff <= (ute_ff && user_read_attempt) || (rwe_ff && !rwe_clr);
            // only a read reset leaves margin mode
            mgn_act_ff <= (start_w && mre_ff) || (mgn_act_ff && !read_reset);
            mgn_lvl_ff <= (start_w && mre_ff) ? mrv_ff : mgn_lvl_ff;
        end
    end

    // read mux; protected data reads zero while a test runs
    logic [31:0] ctrl_rd, sig_rd;
    always_comb begin
        ctrl_rd = flutm_pkg::ZERO_WORD;
        ctrl_rd[flutm_pkg::BIT_UTE] = ute_ff;
        ctrl_rd[flutm_pkg::BIT_AIE] = aie_ff;
        ctrl_rd[flutm_pkg::BIT_AID] = aid_ff;
        ctrl_rd[flutm_pkg::BIT_EIE] = eie_ff && aid_ff;
        ctrl_rd[flutm_pkg::BIT_AIS] = ais_ff && aid_ff;
        ctrl_rd[flutm_pkg::BIT_MRE] = mre_ff && aid_ff;
        ctrl_rd[flutm_pkg::BIT_MRV] = mrv_ff && aid_ff;
        ctrl_rd[flutm_pkg::SYN_LSB +: flutm_pkg::SYN_W] = aid_ff ? syn_ff : 8'h00;
        sig_rd = flutm_pkg::ZERO_WORD;
        for (int k = 0; k < flutm_pkg::SIG_WORDS; k++) begin
            sig_rd = sig_rd | ((sig_hit[k] && aid_ff) ? sig_ff[k] : flutm_pkg::ZERO_WORD);
        end
    end
    wire [31:0] rd_mux = hit_ctrl ? ctrl_rd :
                         (hit_dlo && aid_ff) ? dlo_ff :
                         (hit_dhi && aid_ff) ? dhi_ff :
                         hit_bsel ? 32'(bsel_ff) :
                         hit_lock ? 32'(lock_ff) :
                         hit_slock ? 32'(slock_ff) :
                         hit_stat ? 32'(rwe_ff) : sig_rd;

    // no wait state; every bus output leaves a flop
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_ff <= flutm_pkg::ZERO_WORD;
            pready_ff <= 1'b0;
            pslverr_ff <= 1'b0;
        end else begin
            prdata_ff <= (setup_w && !pwrite) ? rd_mux : flutm_pkg::ZERO_WORD;
            pready_ff <= setup_w;
            pslverr_ff <= setup_w && !map_hit;
        end
    end

    assign prdata = prdata_ff;
    assign pready = pready_ff;
    assign pslverr = pslverr_ff;
    assign test_mode_active = ute_ff;
    assign arr_rd_req = req_ff;
    assign arr_addr = addr_ff;
    assign margin_read_enable = mgn_act_ff;
    assign margin_level = mgn_lvl_ff;
    assign ecc_force_en = ecc_ff;
    assign forced_data = {dhi_ff, dlo_ff};
    assign forced_syndrome = syn_ff;

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    rwe_set_a: assert property (ute_ff && user_read_attempt |=> rwe_ff)
        else $error("read error flag not set");
    sig_fold_a: assert property (fold |=> sig_ff[$past(pass_ff)] == $past(misr_nxt))
        else $error("signature word not folded");
    pass_step_a: assert property (pass_end && !finish |=> pass_ff == $past(pass_ff) + 3'h1)
        else $error("pass order broken");
    elig_req_a: assert property ($rose(req_ff) && !ecc_ff |-> bsel_ff[addr_ff[AW-1:PAGE_W]] &&
        !lock_ff[addr_ff[AW-1:PAGE_W]] && !slock_ff[addr_ff[AW-1:PAGE_W]])
        else $error("read of ineligible block");
    seed_wr_a: assert property (wr_w && sig_hit[0] && aid_ff && !fold |=> sig_ff[0] == $past(pwdata))
        else $error("signature seed lost");
    ute_pw_a: assert property ($rose(ute_ff) |-> $past(pw_w))
        else $error("enable set without password");
    abort_done_a: assert property (st_ff != flutm_pkg::ST_IDLE && !aie_ff |=> aid_ff &&
        st_ff == flutm_pkg::ST_IDLE)
        else $error("abort did not complete");
    margin_hold_a: assert property (st_ff == flutm_pkg::ST_READ && arr_rd_ack && mre_ff && aie_ff
        |=> !fold [*4])
        else $error("margin read sampled early");
    margin_keep_a: assert property (mgn_act_ff && !read_reset |=> mgn_act_ff)
        else $error("margin mode left without read reset");
    prot_wr_a: assert property (wr_w && hit_dlo && !aid_ff |=> $stable(dlo_ff))
        else $error("protected write took effect");

    ecc_done_c: cover property (ecc_ff && finish && aie_ff);
    scan_done_c: cover property (!ecc_ff && finish && aie_ff && !mre_ff);
    margin_done_c: cover property (mgn_act_ff && finish && aie_ff);
    abort_c: cover property (st_ff == flutm_pkg::ST_STEP && !aie_ff);
endmodule

// ===== tb/flutm_top_tb.sv
// flutm_top_tb: self-checking apb bench for the flash user test block.
// assumes 4 blocks of 4 pages; the bench plays the array and its ecc path.
`timescale 1ns/100ps
module flutm_top_tb;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic ura = 1'b0, rrst = 1'b0, ack = 1'b0, pend = 1'b0, stall = 1'b0;
    logic pready, pslverr, slv, tma, req, margin_read_enable_bit, mrl, efe;
    logic [7:0] paddr = 8'h00, fsyn;
    logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
    logic [31:0] ew [5];
    logic [3:0] addr;
    logic [127:0] adata = 128'h0;
    logic [15:0] achk = 16'h0000;
    logic [1:0] asec = 2'h0, aded = 2'h0;
    logic [63:0] fdata;
    int error_cnt = 0, n_checks = 0, n_req = 0, bad_req = 0, cyc = 0, d0, d1, r0;

    flutm_top #(.NUM_BLOCKS(4), .PAGE_W(2)) dut_u (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .user_read_attempt(ura),
        .read_reset(rrst), .test_mode_active(tma), .arr_rd_req(req), .arr_addr(addr),
        .arr_rd_ack(ack), .arr_data(adata), .arr_check(achk), .arr_sec(asec),
        .arr_ded(aded), .margin_read_enable(margin_read_enable_bit), .margin_level(mrl),
        .ecc_force_en(efe), .forced_data(fdata), .forced_syndrome(fsyn));

    initial forever #5 pclk = ~pclk;

    function automatic logic [31:0] slc(input logic [3:0] a, input int k);
        return {16'h5A00, 8'(k), 4'h0, a};
    endfunction

    function automatic logic [31:0] fold(input logic [31:0] w, input logic [31:0] s);
        return {w[30:0], 1'b0} ^ (w[31] ? flutm_pkg::MISR_TAPS : 32'h0000_0000) ^ s;
    endfunction

    // array answers one cycle after a request; a stall keeps the answer pending
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            error_cnt++;
            print_verdict();
        end
        ack <= (req | pend) & ~stall;
        pend <= (req | pend) & stall;
        if (req) begin
            n_req <= n_req + 1;
            if (!efe && addr[3:2] != 2'h1) bad_req <= bad_req + 1;
            adata <= efe ? {2{fdata}} : {slc(addr, 3), slc(addr, 2), slc(addr, 1), slc(addr, 0)};
            achk <= efe ? {2{fsyn}} : {4'h0, addr, 8'h3C};
            asec <= efe ? 2'h0 : 2'h1;
            aded <= efe ? 2'h0 : 2'h2;
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // only the bench-wide cycle ceiling ends this wait
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        slv = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rchk(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0000_0000);
        chk(rd, e);
    endtask

    task automatic run(input logic [31:0] c, output int d);
        int t0;
        t0 = cyc;
        r0 = n_req;
        apb(1'b1, flutm_pkg::OFS_CTRL, c);
        do apb(1'b0, flutm_pkg::OFS_CTRL, 32'h0000_0000);
        while (rd[0] !== 1'b1);
        d = cyc - t0;
    endtask

    task automatic sigs(input logic w);
        for (int i = 0; i < 5; i++) begin
            if (w) apb(1'b1, flutm_pkg::OFS_SIG0 + 8'(4 * i), ew[i]);
            rchk(flutm_pkg::OFS_SIG0 + 8'(4 * i), ew[i]);
        end
    endtask

    task automatic print_verdict();
        $display("checks %0d errors %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask

    initial begin
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        rchk(flutm_pkg::OFS_CTRL, 32'h0000_0001);
        rchk(flutm_pkg::OFS_BLOCK, 32'h0000_000F);
        rchk(8'h40, 32'h0000_0000);
        chk({31'h0, slv}, 32'h0000_0001);
        apb(1'b1, flutm_pkg::OFS_CTRL, 32'h8000_0002);
        rchk(flutm_pkg::OFS_CTRL, 32'h0000_0001);
        for (int k = 0; k < 2; k++) begin
            @(posedge pclk) ura <= 1'b1;
            @(posedge pclk) ura <= 1'b0;
            rchk(flutm_pkg::OFS_STAT, 32'(k));
            apb(1'b1, flutm_pkg::OFS_STAT, 32'h0000_0001);
            apb(1'b1, flutm_pkg::OFS_CTRL, flutm_pkg::TEST_PASSWORD);
            // the enable flop moves on the access edge; look once it has settled
            @(negedge pclk);
            chk({31'h0, tma}, 32'h0000_0001);
        end
        rchk(flutm_pkg::OFS_STAT, 32'h0000_0000);
        for (int i = 0; i < 5; i++) ew[i] = 32'h8765_4321 ^ i;
        sigs(1'b1);
        apb(1'b1, flutm_pkg::OFS_DLO, 32'h5555_5555);
        apb(1'b1, flutm_pkg::OFS_DHI, 32'hAAAA_AAAA);
        apb(1'b1, flutm_pkg::OFS_CTRL, 32'h80FF_0008);
        stall <= 1'b1;
        apb(1'b1, flutm_pkg::OFS_CTRL, 32'h80FF_000A);
        rchk(flutm_pkg::OFS_CTRL, 32'h8000_0002);
        rchk(flutm_pkg::OFS_SIG0, 32'h0000_0000);
        apb(1'b1, flutm_pkg::OFS_DLO, 32'h0000_0000);
        @(negedge pclk);
        chk({efe, 7'h0, fsyn, fdata[47:32]}, 32'h80FF_AAAA);
        chk(fdata[31:0], 32'h5555_5555);
        stall <= 1'b0;
        // execute stays set here, so this write only waits for done
        run(32'h80FF_000A, d0);
        for (int i = 0; i < 5; i++)
            ew[i] = fold(ew[i], i == 4 ? 32'h00FF_00FF : (i[0] ? 32'hAAAA_AAAA : 32'h5555_5555));
        sigs(1'b0);
        rchk(flutm_pkg::OFS_DLO, 32'h5555_5555);
        // regular blocks only, select fixed while scanning
        // block 1 open; block 2 selected but locked
        apb(1'b1, flutm_pkg::OFS_CTRL, 32'h8000_0000);
        apb(1'b1, flutm_pkg::OFS_BSEL, 32'h0000_0006);
        apb(1'b1, flutm_pkg::OFS_BLOCK, 32'hFFFF_FFFD);
        apb(1'b1, flutm_pkg::OFS_SLOCK, 32'hFFFF_FFFD);
        for (int i = 0; i < 5; i++) ew[i] = 32'h0000_0000;
        sigs(1'b1);
        run(32'h8000_0006, d0);
        chk(32'(n_req - r0), 32'h0000_0014);
        for (int p = 0; p < 5; p++)
            for (int g = 4; g < 8; g++)
                ew[p] = fold(ew[p], p < 4 ? slc(4'(g), p) : {16'h0200 + 16'(g), 16'h013C});
        sigs(1'b0);
        apb(1'b1, flutm_pkg::OFS_CTRL, 32'h8000_0000);
        run(32'h8000_0002, d1);
        chk(32'(n_req - r0), 32'h0000_0014);
        chk({31'h0, d1 > d0}, 32'h0000_0001);
        apb(1'b1, flutm_pkg::OFS_CTRL, 32'h8000_0000);
        stall <= 1'b1;
        apb(1'b1, flutm_pkg::OFS_CTRL, 32'h8000_0006);
        rchk(flutm_pkg::OFS_CTRL, 32'h8000_0002);
        apb(1'b1, flutm_pkg::OFS_CTRL, 32'h8000_0000);
        apb(1'b0, flutm_pkg::OFS_CTRL, 32'h0000_0000);
        chk({31'h0, rd[0]}, 32'h0000_0001);
        stall <= 1'b0;
        // two short factory margin runs, sequential order only
        for (int v = 0; v < 2; v++) begin
            apb(1'b1, flutm_pkg::OFS_CTRL, 32'h8000_0024 | 32'(v << 4));
            run(32'h8000_0026 | 32'(v << 4), d1);
            chk({30'h0, margin_read_enable_bit, mrl}, 32'h0000_0002 | 32'(v));
            chk({31'h0, d1 > d0 + 80}, 32'h0000_0001);
            apb(1'b1, flutm_pkg::OFS_CTRL, 32'h8000_0000);
            // give the write's edge time to settle before looking
            @(negedge pclk);
            chk({31'h0, margin_read_enable_bit}, 32'h0000_0001);
            @(posedge pclk) rrst <= 1'b1;
            @(posedge pclk) rrst <= 1'b0;
            @(negedge pclk);
            chk({31'h0, margin_read_enable_bit}, 32'h0000_0000);
        end
        chk(32'(bad_req), 32'h0000_0000);
        print_verdict();
    end
endmodule
